//--- verilog/pcr_defs.svh
`ifndef PCR_DEFS_SVH
`define PCR_DEFS_SVH

// ----------------------------------------------------------------
// Role codes
// ----------------------------------------------------------------
`define PCR_ROLE_STANDARD   8'h00
`define PCR_ROLE_ACTIVE     8'h01
`define PCR_ROLE_STANDBY1   8'h02
`define PCR_ROLE_STANDBY2   8'h03
`define PCR_ROLE_STANDBY3   8'h04

// ----------------------------------------------------------------
// APB register offsets
// ----------------------------------------------------------------
`define PCR_OFF_ROLE        12'h000
`define PCR_OFF_EN1         12'h004
`define PCR_OFF_EN2         12'h008
`define PCR_OFF_EN3         12'h00C
`define PCR_OFF_DIS1        12'h010
`define PCR_OFF_DIS2        12'h014
`define PCR_OFF_DIS3        12'h018
`define PCR_OFF_OTP         12'h01C
`define PCR_OFF_STATUS      12'h020

// ----------------------------------------------------------------
// Reset values; load share full scale 8.0V = 12'hFFF
// ----------------------------------------------------------------
`define PCR_RST_EN1         12'h666
`define PCR_RST_EN2         12'h9EB
`define PCR_RST_EN3         12'hD70
`define PCR_RST_DIS1        12'h2E1
`define PCR_RST_DIS2        12'h605
`define PCR_RST_DIS3        12'h90A
// Temperature in whole degrees C
`define PCR_RST_OTP_TRIP    8'h64
`define PCR_OTP_HYST        8'h05

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PCR_CLK_HZ          100000000
`define PCR_WAKE_US         100
`define PCR_WAKE_CYC        ((`PCR_WAKE_US * (`PCR_CLK_HZ / 1000000)))
`define PCR_BLINK1_HZ       1
`define PCR_BLINK_HALF_1HZ  (`PCR_CLK_HZ / (2 * `PCR_BLINK1_HZ))
`endif

//--- verilog/pcr_pkg.sv
package pcr_pkg;
  typedef enum logic [2:0] {
    PCR_LED_OFF,
    PCR_LED_GREEN,
    PCR_LED_GREEN_1HZ,
    PCR_LED_GREEN_2HZ,
    PCR_LED_AMBER,
    PCR_LED_AMBER_1HZ
  } pcr_led_mode_t;

  typedef enum logic [1:0] {
    PCR_ST_ON,
    PCR_ST_STANDBY,
    PCR_ST_OTP
  } pcr_state_t;
endpackage

//--- verilog/pcr_led.sv
`timescale 1ns/1ps
`include "pcr_defs.svh"
module pcr_led (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire pcr_pkg::pcr_led_mode_t mode,
  output logic                        led_green,
  output logic                        led_amber
);
  typedef struct packed {
    logic [25:0] cnt;
    logic        ph1;
    logic        ph2;
    logic        green;
    logic        amber;
  } pcr_led_st_t;

  localparam logic [25:0] HALF1 = 26'(`PCR_BLINK_HALF_1HZ - 1);
  localparam logic [25:0] QUART = 26'(`PCR_BLINK_HALF_1HZ / 2 - 1);

  pcr_led_st_t s_reg;
  pcr_led_st_t s_next;

  // ----------------------------------------------------------------
  // Blink phases
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    // Half-period counter; 2Hz phase flips at each quarter, 1Hz at each half
    if (s_reg.cnt == HALF1)
    begin
      s_next.cnt = 26'h0000_000;
      s_next.ph1 = ~s_reg.ph1;
      s_next.ph2 = ~s_reg.ph2;
    end
    else
    begin
      s_next.cnt = s_reg.cnt + 26'h000_0001;
      if (s_reg.cnt == QUART)
        s_next.ph2 = ~s_reg.ph2;
    end
    s_next.green = 1'b0;
    s_next.amber = 1'b0;
    case (mode)
      pcr_pkg::PCR_LED_GREEN:     s_next.green = 1'b1;
      pcr_pkg::PCR_LED_GREEN_1HZ: s_next.green = s_reg.ph1;
      pcr_pkg::PCR_LED_GREEN_2HZ: s_next.green = s_reg.ph2;
      pcr_pkg::PCR_LED_AMBER:     s_next.amber = 1'b1;
      pcr_pkg::PCR_LED_AMBER_1HZ: s_next.amber = s_reg.ph1;
      default:                    s_next.green = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign led_green = s_reg.green;
  assign led_amber = s_reg.amber;
endmodule

//--- verilog/pcr_apb_regs.sv
`timescale 1ns/1ps
`include "pcr_defs.svh"
module pcr_apb_regs (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [7:0]  status_in,
  output logic [7:0]       role,
  output logic             role_valid,
  output logic [11:0]      en1,
  output logic [11:0]      en2,
  output logic [11:0]      en3,
  output logic [11:0]      dis1,
  output logic [11:0]      dis2,
  output logic [11:0]      dis3,
  output logic [7:0]       otp_trip
);
  typedef struct packed {
    logic [7:0]  role;
    logic        role_valid;
    logic [11:0] en1;
    logic [11:0] en2;
    logic [11:0] en3;
    logic [11:0] dis1;
    logic [11:0] dis2;
    logic [11:0] dis3;
    logic [7:0]  otp;
    logic [31:0] rdata;
    logic        err;
  } pcr_regs_st_t;

  pcr_regs_st_t s_reg;
  pcr_regs_st_t s_next;
  logic         acc;
  logic         hit;

  assign acc = psel & penable;

  always_comb
  begin
    s_next = s_reg;
    hit    = 1'b1;
    if (acc && pwrite)
    begin
      case (paddr)
        `PCR_OFF_ROLE:
        begin
          s_next.role       = pwdata[7:0];
          s_next.role_valid = 1'b1;
        end
        `PCR_OFF_EN1:  s_next.en1 = pwdata[11:0];
        `PCR_OFF_EN2:  s_next.en2 = pwdata[11:0];
        `PCR_OFF_EN3:  s_next.en3 = pwdata[11:0];
        `PCR_OFF_DIS1: s_next.dis1 = pwdata[11:0];
        `PCR_OFF_DIS2: s_next.dis2 = pwdata[11:0];
        `PCR_OFF_DIS3: s_next.dis3 = pwdata[11:0];
        `PCR_OFF_OTP:  s_next.otp = pwdata[7:0];
        `PCR_OFF_STATUS: hit = 1'b0;
        default:       hit = 1'b0;
      endcase
    end
    else if (acc)
    begin
      case (paddr)
        `PCR_OFF_ROLE:   s_next.rdata = {23'h00_0000, s_reg.role_valid, s_reg.role};
        `PCR_OFF_EN1:    s_next.rdata = {20'h0_0000, s_reg.en1};
        `PCR_OFF_EN2:    s_next.rdata = {20'h0_0000, s_reg.en2};
        `PCR_OFF_EN3:    s_next.rdata = {20'h0_0000, s_reg.en3};
        `PCR_OFF_DIS1:   s_next.rdata = {20'h0_0000, s_reg.dis1};
        `PCR_OFF_DIS2:   s_next.rdata = {20'h0_0000, s_reg.dis2};
        `PCR_OFF_DIS3:   s_next.rdata = {20'h0_0000, s_reg.dis3};
        `PCR_OFF_OTP:    s_next.rdata = {24'h00_0000, s_reg.otp};
        `PCR_OFF_STATUS: s_next.rdata = {24'h00_0000, status_in};
        default:
        begin
          s_next.rdata = 32'h0000_0000;
          hit          = 1'b0;
        end
      endcase
    end
    s_next.err = acc & ~hit;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s_reg      <= '0;
      s_reg.en1  <= `PCR_RST_EN1;
      s_reg.en2  <= `PCR_RST_EN2;
      s_reg.en3  <= `PCR_RST_EN3;
      s_reg.dis1 <= `PCR_RST_DIS1;
      s_reg.dis2 <= `PCR_RST_DIS2;
      s_reg.dis3 <= `PCR_RST_DIS3;
      s_reg.otp  <= `PCR_RST_OTP_TRIP;
    end
    else
      s_reg <= s_next;
  end

  // Zero wait states: data and error are valid in the access cycle
  assign pready     = 1'b1;
  assign prdata     = s_next.rdata;
  assign pslverr    = s_next.err;
  assign role       = s_reg.role;
  assign role_valid = s_reg.role_valid;
  assign en1        = s_reg.en1;
  assign en2        = s_reg.en2;
  assign en3        = s_reg.en3;
  assign dis1       = s_reg.dis1;
  assign dis2       = s_reg.dis2;
  assign dis3       = s_reg.dis3;
  assign otp_trip   = s_reg.otp;
endmodule

//--- verilog/pcr_ctrl.sv
`timescale 1ns/1ps
`include "pcr_defs.svh"
module pcr_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [11:0] load_share_sample,
  input  wire logic [7:0]  temperature,
  input  wire logic        ac_present,
  input  wire logic        peer_ac_present,
  input  wire logic        output_below_fault,
  input  wire logic        overcurrent_protection,
  input  wire logic        overvoltage_protection,
  input  wire logic        fan_fail,
  input  wire logic        warning,
  input  wire logic        fw_update,
  input  wire logic        supply_on_request_n,
  input  wire logic        converter_active_n,
  input  wire logic        cold_redundancy_line_in,
  output logic             cold_redundancy_line_out,
  output logic             cold_redundancy_line_oe,
  output logic             main_output_on,
  output logic             standby_rail_on,
  output logic             led_green,
  output logic             led_amber
);
  localparam logic [13:0] WAKE_CYC = 14'(`PCR_WAKE_CYC);

  typedef struct packed {
    pcr_pkg::pcr_state_t state;
    logic                latched;
    logic                son_prev;
    logic                ac_prev;
    logic [13:0]         wake_cnt;
    logic                out_on;
    logic                cr_drive_low;
    logic                cr_drive_high;
  } pcr_st_t;

  pcr_st_t                s_reg;
  pcr_st_t                s_next;
  logic [7:0]             role;
  logic                   role_valid;
  logic [11:0]            en1;
  logic [11:0]            en2;
  logic [11:0]            en3;
  logic [11:0]            dis1;
  logic [11:0]            dis2;
  logic [11:0]            dis3;
  logic [7:0]             otp_trip;
  logic [7:0]             status;
  logic                   is_standby_role;
  logic                   is_driver_role;
  logic [11:0]            thr_on;
  logic [11:0]            thr_off;
  logic                   fault;
  logic                   crit;
  logic                   otp_hot;
  logic                   otp_cool;
  pcr_pkg::pcr_led_mode_t led_mode;

  // ----------------------------------------------------------------
  // Register block
  // ----------------------------------------------------------------
  pcr_apb_regs u_regs (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .pready     (pready),
    .prdata     (prdata),
    .pslverr    (pslverr),
    .status_in  (status),
    .role       (role),
    .role_valid (role_valid),
    .en1        (en1),
    .en2        (en2),
    .en3        (en3),
    .dis1       (dis1),
    .dis2       (dis2),
    .dis3       (dis3),
    .otp_trip   (otp_trip)
  );

  // ----------------------------------------------------------------
  // Role decode and threshold choice
  // ----------------------------------------------------------------
  always_comb
  begin
    is_standby_role = 1'b0;
    thr_on          = en1;
    thr_off         = dis1;
    case (role)
      `PCR_ROLE_STANDBY1:
      begin
        is_standby_role = role_valid;
        thr_on          = en1;
        thr_off         = dis1;
      end
      `PCR_ROLE_STANDBY2:
      begin
        is_standby_role = role_valid;
        thr_on          = en2;
        thr_off         = dis2;
      end
      `PCR_ROLE_STANDBY3:
      begin
        is_standby_role = role_valid;
        thr_on          = en3;
        thr_off         = dis3;
      end
      default: is_standby_role = 1'b0;
    endcase
  end

  // Standard and active roles drive the line high once a role has been written; unknown codes behave as standard
  assign is_driver_role = role_valid & ~is_standby_role;
  assign crit           = s_reg.latched | fan_fail;
  assign fault          = crit | output_below_fault | (s_reg.state == pcr_pkg::PCR_ST_OTP);
  assign otp_hot        = temperature >= otp_trip;
  // Recovery only well below the trip point to avoid on/off chatter
  assign otp_cool       = temperature < (otp_trip - `PCR_OTP_HYST);

  // ----------------------------------------------------------------
  // Main control
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next          = s_reg;
    s_next.son_prev = supply_on_request_n;
    s_next.ac_prev  = ac_present;
    if (overcurrent_protection || overvoltage_protection)
      s_next.latched = 1'b1;
    // Clear on supply-on toggle or AC drop; a fresh trip the same cycle still wins
    else if ((supply_on_request_n != s_reg.son_prev) || (s_reg.ac_prev && !ac_present))
      s_next.latched = 1'b0;
    s_next.wake_cnt = 14'h0000;
    case (s_reg.state)
      pcr_pkg::PCR_ST_ON:
      begin
        if (otp_hot)
          s_next.state = pcr_pkg::PCR_ST_OTP;
        // Drop to standby only below disable level, with a live driver on the line
        else if (is_standby_role && cold_redundancy_line_in && !fault &&
                 (load_share_sample < thr_off))
          s_next.state = pcr_pkg::PCR_ST_STANDBY;
      end
      pcr_pkg::PCR_ST_STANDBY:
      begin
        if (otp_hot)
          s_next.state = pcr_pkg::PCR_ST_OTP;
        // Line low means a peer fault or no active driver: wake at once
        else if (!cold_redundancy_line_in)
          s_next.state = pcr_pkg::PCR_ST_ON;
        else if (load_share_sample >= thr_on)
          s_next.state = pcr_pkg::PCR_ST_ON;
        else if (!is_standby_role)
          s_next.state = pcr_pkg::PCR_ST_ON;
      end
      pcr_pkg::PCR_ST_OTP:
      begin
        if (otp_cool)
          s_next.state = pcr_pkg::PCR_ST_ON;
      end
      default: s_next.state = pcr_pkg::PCR_ST_ON;
    endcase
    // Wake-latency counter, read nowhere; counts in standby while the line is low, which already wakes next cycle
    if ((s_reg.state == pcr_pkg::PCR_ST_STANDBY) && !cold_redundancy_line_in &&
        (s_reg.wake_cnt < WAKE_CYC))
      s_next.wake_cnt = s_reg.wake_cnt + 14'h0001;
    // Converter-active input is not consulted in any role; it only feeds the status register
    s_next.out_on        = (s_next.state == pcr_pkg::PCR_ST_ON) && !crit &&
                           !supply_on_request_n;
    s_next.cr_drive_low  = fault;
    s_next.cr_drive_high = is_driver_role && !fault;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s_reg          <= '0;
      s_reg.state    <= pcr_pkg::PCR_ST_ON;
      s_reg.son_prev <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  // ----------------------------------------------------------------
  // LED priority
  // ----------------------------------------------------------------
  always_comb
  begin
    if (!ac_present && !peer_ac_present)
      led_mode = pcr_pkg::PCR_LED_OFF;
    else if (crit)
      led_mode = pcr_pkg::PCR_LED_AMBER;
    else if (!ac_present)
      led_mode = pcr_pkg::PCR_LED_AMBER;
    else if (warning || s_reg.state == pcr_pkg::PCR_ST_OTP)
      led_mode = pcr_pkg::PCR_LED_AMBER_1HZ;
    else if (fw_update)
      led_mode = pcr_pkg::PCR_LED_GREEN_2HZ;
    else if (!s_reg.out_on)
      led_mode = pcr_pkg::PCR_LED_GREEN_1HZ;
    else
      led_mode = pcr_pkg::PCR_LED_GREEN;
  end

  pcr_led u_led (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .mode      (led_mode),
    .led_green (led_green),
    .led_amber (led_amber)
  );

  assign status = {3'h0, converter_active_n, s_reg.latched, s_reg.out_on,
                   (s_reg.state == pcr_pkg::PCR_ST_OTP), (s_reg.state == pcr_pkg::PCR_ST_STANDBY)};

  assign main_output_on           = s_reg.out_on;
  assign standby_rail_on          = 1'b1;
  assign cold_redundancy_line_out = ~s_reg.cr_drive_low;
  assign cold_redundancy_line_oe  = s_reg.cr_drive_low | s_reg.cr_drive_high;
endmodule

//--- tb/pcr_peer_model.sv
`timescale 1ns/1ps
module pcr_peer_model (
  input  wire logic cold_redundancy_line_out,
  input  wire logic cold_redundancy_line_oe,
  input  wire logic peer_drive_high,
  input  wire logic peer_pull_low,
  output logic      line_level
);
  // ----------------------------------------------------------------
  // Shared line resolution
  // ----------------------------------------------------------------
  logic low_any;
  logic high_any;

  // A healthy active peer drives high, a faulted one pulls low; low wins
  assign low_any  = peer_pull_low || (cold_redundancy_line_oe && !cold_redundancy_line_out);
  assign high_any = peer_drive_high || (cold_redundancy_line_oe && cold_redundancy_line_out);
  // Bias resistor takes an undriven line low, so nobody driving reads as wake
  assign line_level = !low_any && high_any;
endmodule

//--- tb/pcr_ctrl_checker.sv
`timescale 1ns/1ps
module pcr_ctrl_checker (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic [7:0] temperature,
  input wire logic       ac_present,
  input wire logic       peer_ac_present,
  input wire logic       output_below_fault,
  input wire logic       overcurrent_protection,
  input wire logic       overvoltage_protection,
  input wire logic       fan_fail,
  input wire logic       supply_on_request_n,
  input wire logic       cold_redundancy_line_in,
  input wire logic       cold_redundancy_line_out,
  input wire logic       cold_redundancy_line_oe,
  input wire logic       main_output_on,
  input wire logic       standby_rail_on,
  input wire logic       led_green,
  input wire logic       led_amber
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // Trip level at its reset value; reprogramming it would need this changed
  localparam logic [7:0] OTP_TRIP = 8'h64;
  logic healthy;

  assign healthy = !supply_on_request_n && (temperature < OTP_TRIP - 8'h05) && !overcurrent_protection &&
                   !overvoltage_protection && !output_below_fault && !fan_fail && ac_present;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_ocp_hit;
    overcurrent_protection [*3];
  endsequence
  sequence s_ocp_quiet;
    (!overcurrent_protection && $stable(supply_on_request_n) && ac_present) [*4];
  endsequence

  AST_RAIL_ON: assert property (standby_rail_on) else $error("standby rail dropped");
  AST_OTP_OFF: assert property ((temperature >= OTP_TRIP) [*2] |-> ##1 !main_output_on)
    else $error("output on while over temperature");
  AST_OTP_HYST: assert property ($rose(main_output_on) |-> $past(temperature) <= OTP_TRIP - 8'h04)
    else $error("output rose inside hysteresis band");
  AST_FAULT_LOW: assert property (output_below_fault [*3] |-> !(cold_redundancy_line_oe && cold_redundancy_line_out))
    else $error("line driven high during fault");
  AST_WAKE: assert property ($fell(cold_redundancy_line_in) && !main_output_on && healthy |-> ##[1:3] main_output_on)
    else $error("no wake after line pulled low");
  AST_OCP_LATCH: assert property (s_ocp_hit ##1 s_ocp_quiet |-> !main_output_on)
    else $error("overcurrent shutdown did not latch");
  AST_LED_EXCL: assert property (!(led_green && led_amber)) else $error("both colours lit");
  AST_DARK: assert property ((!ac_present && !peer_ac_present) [*3] |-> !led_green && !led_amber)
    else $error("led lit without any input power");
  AST_CRIT: assert property ((fan_fail && ac_present) [*3] |-> led_amber && !led_green)
    else $error("critical event not amber");
  AST_AC_LOSS: assert property ((!ac_present && peer_ac_present && !fan_fail &&
    !overcurrent_protection && !overvoltage_protection) [*3] |-> led_amber && !led_green)
    else $error("input loss not amber");
endmodule

bind pcr_ctrl pcr_ctrl_checker u_chk (.sys_clk(sys_clk), .rst(rst), .temperature(temperature),
  .ac_present(ac_present), .peer_ac_present(peer_ac_present), .output_below_fault(output_below_fault),
  .overcurrent_protection(overcurrent_protection), .overvoltage_protection(overvoltage_protection),
  .fan_fail(fan_fail), .supply_on_request_n(supply_on_request_n), .cold_redundancy_line_in(cold_redundancy_line_in),
  .cold_redundancy_line_out(cold_redundancy_line_out), .cold_redundancy_line_oe(cold_redundancy_line_oe),
  .main_output_on(main_output_on), .standby_rail_on(standby_rail_on), .led_green(led_green), .led_amber(led_amber));

//--- tb/psu_cold_redundancy_ctrl_tb.sv
`timescale 1ns/1ps
`include "pcr_defs.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module psu_cold_redundancy_ctrl_tb;
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr, load_share_sample;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  temperature;
  logic        ac_present, peer_ac_present, output_below_fault, overcurrent_protection, overvoltage_protection;
  logic        fan_fail, warning, fw_update, supply_on_request_n, converter_active_n, er;
  logic        cold_redundancy_line_in, cold_redundancy_line_out, cold_redundancy_line_oe;
  logic        main_output_on, standby_rail_on, led_green, led_amber, peer_drive_high, peer_pull_low;
  int          failures;
  int          comparisons;
  localparam logic [11:0] EN_T [3]  = '{`PCR_RST_EN1, `PCR_RST_EN2, `PCR_RST_EN3};
  localparam logic [11:0] DIS_T [3] = '{`PCR_RST_DIS1, `PCR_RST_DIS2, `PCR_RST_DIS3};

  pcr_ctrl u_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .load_share_sample(load_share_sample),
    .temperature(temperature), .ac_present(ac_present), .peer_ac_present(peer_ac_present),
    .output_below_fault(output_below_fault), .overcurrent_protection(overcurrent_protection),
    .overvoltage_protection(overvoltage_protection), .fan_fail(fan_fail), .warning(warning), .fw_update(fw_update),
    .supply_on_request_n(supply_on_request_n), .converter_active_n(converter_active_n),
    .cold_redundancy_line_in(cold_redundancy_line_in), .cold_redundancy_line_out(cold_redundancy_line_out),
    .cold_redundancy_line_oe(cold_redundancy_line_oe), .main_output_on(main_output_on),
    .standby_rail_on(standby_rail_on), .led_green(led_green), .led_amber(led_amber));
  pcr_peer_model u_peer (.cold_redundancy_line_out(cold_redundancy_line_out),
    .cold_redundancy_line_oe(cold_redundancy_line_oe), .peer_drive_high(peer_drive_high),
    .peer_pull_low(peer_pull_low), .line_level(cold_redundancy_line_in));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task close_out;
    $display("checks %0d mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Holds the request until pready is seen at an edge, then idles one cycle
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 50)
    begin
      failures++;
      close_out();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task await_out(input logic v, input int lim);
    int n;
    n = 0;
    while (main_output_on !== v && n < lim)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (main_output_on !== v)
    begin
      failures++;
      $display("BAD wait main_output_on exp %0h got %0h", v, main_output_on);
      close_out();
    end
  endtask

  task settle;
    repeat (6) @(posedge sys_clk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    await_out(1'b1, 5);
    `CHK("default_on", 1'b1, main_output_on)
    `CHK("no_drive", 1'b0, cold_redundancy_line_oe)
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b0, `PCR_OFF_EN1 + 12'(4 * i), 32'h0000_0000);
      `CHK("en_reset", 32'(EN_T[i]), rd)
      apb(1'b0, `PCR_OFF_DIS1 + 12'(4 * i), 32'h0000_0000);
      `CHK("dis_reset", 32'(DIS_T[i]), rd)
    end
    apb(1'b0, 12'h024, 32'h0000_0000);
    `CHK("unmapped_err", 1'b1, er)
    $display("test reset done");
  endtask

  task t_standby;
    peer_drive_high <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, `PCR_OFF_ROLE, 32'(i + 2));
      load_share_sample <= 12'h0100;
      await_out(1'b0, 12);
      `CHK("standby_off", 1'b0, main_output_on)
      `CHK("line_open", 1'b0, cold_redundancy_line_oe)
      load_share_sample <= EN_T[i] - 12'h001;
      settle();
      `CHK("below_en", 1'b0, main_output_on)
      load_share_sample <= EN_T[i];
      await_out(1'b1, 5);
      `CHK("at_en", 1'b1, main_output_on)
      load_share_sample <= DIS_T[i];
      settle();
      `CHK("at_dis", 1'b1, main_output_on)
      load_share_sample <= DIS_T[i] - 12'h001;
      await_out(1'b0, 5);
      `CHK("below_dis", 1'b0, main_output_on)
    end
    apb(1'b0, `PCR_OFF_STATUS, 32'h0000_0000);
    `CHK("status", 32'h0000_0001, rd)
    `CHK("blink_green", 2'b00, {led_green, led_amber})
    peer_pull_low <= 1'b1;
    @(posedge sys_clk);
    await_out(1'b1, 3);
    `CHK("wake_on_low", 1'b1, main_output_on)
    peer_pull_low <= 1'b0;
    await_out(1'b0, 12);
    peer_drive_high <= 1'b0;
    await_out(1'b1, 6);
    `CHK("no_driver_on", 1'b1, main_output_on)
    peer_drive_high <= 1'b1;
    await_out(1'b0, 12);
    output_below_fault <= 1'b1;
    settle();
    `CHK("fault_drive", 1'b1, cold_redundancy_line_oe)
    `CHK("fault_low", 1'b0, cold_redundancy_line_out)
    output_below_fault <= 1'b0;
    $display("test standby done");
  endtask

  task t_active;
    apb(1'b1, `PCR_OFF_ROLE, 32'h0000_0000);
    settle();
    `CHK("std_on", 2'b11, {main_output_on, cold_redundancy_line_oe && cold_redundancy_line_out})
    apb(1'b1, `PCR_OFF_ROLE, 32'h0000_0001);
    apb(1'b0, `PCR_OFF_ROLE, 32'h0000_0000);
    `CHK("role_rd", 32'h0000_0101, rd)
    converter_active_n <= 1'b1;
    await_out(1'b1, 6);
    settle();
    `CHK("active_on", 1'b1, main_output_on)
    `CHK("active_drive", 1'b1, cold_redundancy_line_oe && cold_redundancy_line_out)
    temperature <= 8'h64;
    await_out(1'b0, 5);
    `CHK("rail_kept", 1'b1, standby_rail_on)
    temperature <= 8'h60;
    repeat (10) @(posedge sys_clk);
    `CHK("hyst_off", 1'b0, main_output_on)
    temperature <= 8'h5E;
    await_out(1'b1, 5);
    `CHK("otp_back", 1'b1, main_output_on)
    temperature <= 8'h19;
    $display("test active done");
  endtask

  task t_latch;
    overcurrent_protection <= 1'b1;
    repeat (3) @(posedge sys_clk);
    overcurrent_protection <= 1'b0;
    settle();
    `CHK("ocp_held", 1'b0, main_output_on)
    supply_on_request_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    supply_on_request_n <= 1'b0;
    await_out(1'b1, 6);
    overvoltage_protection <= 1'b1;
    repeat (3) @(posedge sys_clk);
    overvoltage_protection <= 1'b0;
    settle();
    `CHK("ovp_held", 1'b0, main_output_on)
    ac_present <= 1'b0;
    repeat (3) @(posedge sys_clk);
    ac_present <= 1'b1;
    await_out(1'b1, 6);
    $display("test latch done");
  endtask

  task t_led;
    settle();
    `CHK("green", 2'b10, {led_green, led_amber})
    ac_present <= 1'b0;
    peer_ac_present <= 1'b0;
    settle();
    `CHK("dark", 2'b00, {led_green, led_amber})
    peer_ac_present <= 1'b1;
    warning <= 1'b1;
    settle();
    `CHK("ac_loss", 2'b01, {led_green, led_amber})
    ac_present <= 1'b1;
    settle();
    `CHK("warn_blink", 2'b00, {led_green, led_amber})
    {warning, fw_update} <= 2'b01;
    settle();
    `CHK("fw_blink", 2'b00, {led_green, led_amber})
    fan_fail <= 1'b1;
    settle();
    `CHK("critical", 2'b01, {led_green, led_amber})
    $display("test led done");
  endtask

  initial
  begin
    failures = 0;
    comparisons = 0;
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    load_share_sample = 12'h000;
    temperature = 8'h19;
    {ac_present, peer_ac_present} = 2'b11;
    {output_below_fault, overcurrent_protection, overvoltage_protection, fan_fail, warning, fw_update} = '0;
    supply_on_request_n = 1'b0;
    converter_active_n = 1'b0;
    {peer_drive_high, peer_pull_low} = 2'b00;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_standby();
    t_active();
    t_latch();
    t_led();
    close_out();
  end
endmodule
